// file: pkg/fbp_pkg.sv
package fbp_pkg;
   // ****************************************
   // geometry
   // ****************************************
   localparam int unsigned FLASH_BYTES  = 32768;
   localparam int unsigned BLOCK_BYTES  = 1024;
   localparam int unsigned REGION_BYTES = 2048;
   localparam int unsigned WORD_BYTES   = 4;
   localparam int unsigned DATA_W       = 32;
   localparam int unsigned FLASH_WORDS  = FLASH_BYTES / WORD_BYTES;
   localparam int unsigned BLOCK_WORDS  = BLOCK_BYTES / WORD_BYTES;
   localparam int unsigned NUM_BLOCKS   = FLASH_BYTES / BLOCK_BYTES;
   localparam int unsigned NUM_REGIONS  = FLASH_BYTES / REGION_BYTES;
   localparam int unsigned ADDR_W       = $clog2(FLASH_WORDS);
   localparam int unsigned BLK_W        = $clog2(NUM_BLOCKS);
   localparam int unsigned REG_W        = $clog2(NUM_REGIONS);
   localparam int unsigned CNT_W        = $clog2(BLOCK_WORDS);

   // ****************************************
   // values
   // ****************************************
   localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffffffff;
   localparam logic [CNT_W-1:0]  ERASE_LAST  = CNT_W'(BLOCK_WORDS - 1);

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      SRC_FETCH,
      SRC_DATA,
      SRC_DEBUG
   } fbp_src_t;

   typedef enum logic {
      ST_IDLE,
      ST_ERASE
   } fbp_state_t;
endpackage

// file: design/fbp_flash_array.sv
`timescale 1ns/100ps
module fbp_flash_array #(
   parameter int unsigned WORDS  = fbp_pkg::FLASH_WORDS,
   parameter int unsigned AW     = fbp_pkg::ADDR_W,
   parameter int unsigned DW     = fbp_pkg::DATA_W
) (
   input  wire logic          clk_in,
   input  wire logic          we_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [DW-1:0] wdata_in,
   input  wire logic          re_in,
   input  wire logic [AW-1:0] raddr_in,
   output logic      [DW-1:0] rdata_out
);
   // ****************************************
   // storage
   // ****************************************
   // no reset: contents are non-volatile in intent
   logic [DW-1:0] mem [WORDS];

   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
      // read during write of same word returns the old value
      if (re_in) begin
         rdata_out <= mem[raddr_in];
      end
   end
endmodule

// file: design/fbp_top.sv
`timescale 1ns/100ps
// Overview of operation
// RULE1: 32 KB flash in 1-KB blocks, each erased alone, others untouched.
// RULE2: an erased block reads back all ones in every bit.
// RULE3: block pairs form 2-KB regions, each read-only or execute-only.
// RULE4: read-only region refuses erase and program, contents never change.
// RULE5: execute-only region refuses erase/program; only instruction fetch may read. Here denied words reach rd_data_out after rd_err_out if no read follows.
// RULE6: permitted read returns data one clock later, no wait states.
// RULE7: protection refusal sets a readable violation flag, flash unchanged.
module fbp_top (
   input  wire logic                          clk_in,
   input  wire logic                          rst_in,
   input  wire logic [fbp_pkg::NUM_REGIONS-1:0] prot_ro_in,
   input  wire logic [fbp_pkg::NUM_REGIONS-1:0] prot_xo_in,
   input  wire logic                          rd_req_in,
   input  wire fbp_pkg::fbp_src_t             rd_src_in,
   input  wire logic [fbp_pkg::ADDR_W-1:0]    rd_addr_in,
   output logic                               rd_valid_out,
   output logic                               rd_err_out,
   output logic      [fbp_pkg::DATA_W-1:0]    rd_data_out,
   input  wire logic                          pgm_req_in,
   input  wire logic [fbp_pkg::ADDR_W-1:0]    pgm_addr_in,
   input  wire logic [fbp_pkg::DATA_W-1:0]    pgm_wdata_in,
   input  wire logic                          ers_req_in,
   input  wire logic [fbp_pkg::BLK_W-1:0]     ers_blk_in,
   output logic                               busy_out,
   output logic                               op_done_out,
   output logic                               op_err_out,
   input  wire logic                          viol_clr_in,
   output logic                               violation_out
);
   // ****************************************
   // state
   // ****************************************
   fbp_pkg::fbp_state_t             state, next_state;
   logic [fbp_pkg::CNT_W-1:0]       cnt, next_cnt;
   logic [fbp_pkg::BLK_W-1:0]       ers_blk, next_ers_blk;
   logic                            next_done, next_err;
   logic                            next_viol;
   logic                            next_rd_valid, next_rd_err;

   logic                            mem_we;
   logic [fbp_pkg::ADDR_W-1:0]      mem_waddr;
   logic [fbp_pkg::DATA_W-1:0]      mem_wdata;
   logic [fbp_pkg::DATA_W-1:0]      mem_rdata;

   logic [fbp_pkg::REG_W-1:0]       rd_region, pgm_region, ers_region;
   logic                            rd_deny, pgm_prot, ers_prot;
   logic                            idle, pgm_take, ers_take;
   logic                            pgm_refuse, ers_refuse;

   // ****************************************
   // protection decode
   // ****************************************
   always_comb begin
      rd_region  = rd_addr_in[fbp_pkg::ADDR_W-1 -: fbp_pkg::REG_W];     // see RULE3
      pgm_region = pgm_addr_in[fbp_pkg::ADDR_W-1 -: fbp_pkg::REG_W];
      ers_region = ers_blk_in[fbp_pkg::BLK_W-1 -: fbp_pkg::REG_W];       // see RULE3
      // only the fetch path may read execute-only code
      rd_deny    = prot_xo_in[rd_region] && (rd_src_in != fbp_pkg::SRC_FETCH); // see RULE5
      pgm_prot   = prot_ro_in[pgm_region] || prot_xo_in[pgm_region];     // see RULE4
      ers_prot   = prot_ro_in[ers_region] || prot_xo_in[ers_region];     // see RULE5
      idle       = (state == fbp_pkg::ST_IDLE);
      // erase wins over a program offered in the same cycle
      ers_take   = ers_req_in && idle;
      pgm_take   = pgm_req_in && idle && !ers_req_in;
      pgm_refuse = pgm_take && pgm_prot;                                 // see RULE4
      ers_refuse = ers_take && ers_prot;                                 // see RULE4
   end

   // ****************************************
   // program / erase sequencer
   // ****************************************
   always_comb begin
      next_state   = state;
      next_cnt     = cnt;
      next_ers_blk = ers_blk;
      next_done    = 1'b0;
      next_err     = pgm_refuse || ers_refuse;                           // see RULE7
      mem_we       = 1'b0;
      mem_waddr    = pgm_addr_in;
      mem_wdata    = pgm_wdata_in;
      unique case (state)
         fbp_pkg::ST_IDLE: begin
            if (ers_take && !ers_prot) begin
               next_state   = fbp_pkg::ST_ERASE;
               next_cnt     = '0;
               next_ers_blk = ers_blk_in;
            end else if (pgm_take && !pgm_prot) begin
               mem_we    = 1'b1;
               next_done = 1'b1;
            end
         end
         fbp_pkg::ST_ERASE: begin
            // one word per cycle, only inside the latched block
            mem_we    = 1'b1;                                            // see RULE1
            mem_waddr = {ers_blk, cnt};                                  // see RULE1
            mem_wdata = fbp_pkg::ERASED_WORD;                            // see RULE2
            next_cnt  = cnt + 1'b1;
            if (cnt == fbp_pkg::ERASE_LAST) begin
               next_state = fbp_pkg::ST_IDLE;
               next_done  = 1'b1;
            end
         end
      endcase
   end

   // ****************************************
   // read path and violation flag
   // ****************************************
   always_comb begin
      next_rd_valid = rd_req_in;                                         // see RULE6
      next_rd_err   = rd_req_in && rd_deny;                              // see RULE5
      // a new refusal wins over a clear in the same cycle
      next_viol     = (violation_out && !viol_clr_in) || next_err;       // see RULE7
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state         <= fbp_pkg::ST_IDLE;
         cnt           <= '0;
         ers_blk       <= '0;
         op_done_out   <= 1'b0;
         op_err_out    <= 1'b0;
         violation_out <= 1'b0;
         rd_valid_out  <= 1'b0;
         rd_err_out    <= 1'b0;
      end else begin
         state         <= next_state;
         cnt           <= next_cnt;
         ers_blk       <= next_ers_blk;
         op_done_out   <= next_done;
         op_err_out    <= next_err;
         violation_out <= next_viol;
         rd_valid_out  <= next_rd_valid;
         rd_err_out    <= next_rd_err;
      end
   end

   assign busy_out = (state == fbp_pkg::ST_ERASE);
   // denied reads show zero in their result cycle; the array output keeps the word until the next read
   assign rd_data_out = rd_err_out ? '0 : mem_rdata;                     // see RULE5

   fbp_flash_array #(
      .WORDS (fbp_pkg::FLASH_WORDS),
      .AW    (fbp_pkg::ADDR_W),
      .DW    (fbp_pkg::DATA_W)
   ) u_array (
      .clk_in    (clk_in),
      .we_in     (mem_we),
      .waddr_in  (mem_waddr),
      .wdata_in  (mem_wdata),
      .re_in     (rd_req_in),
      .raddr_in  (rd_addr_in),
      .rdata_out (mem_rdata)
   );

   // ****************************************
   // assertions
   // ****************************************
   logic [fbp_pkg::CNT_W:0] busy_len;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_len <= '0;
      end else if (busy_out) begin
         busy_len <= busy_len + 1'b1;
      end else begin
         busy_len <= '0;
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   property p_erase_len;
      $fell(busy_out) |-> (busy_len == (fbp_pkg::CNT_W + 1)'(fbp_pkg::BLOCK_WORDS)) && op_done_out;
   endproperty
   a_erase_len: assert property (p_erase_len) else $error("erase length wrong"); // see RULE1

   property p_erase_ones;
      busy_out |-> mem_we && (mem_wdata == fbp_pkg::ERASED_WORD)
                   && (mem_waddr[fbp_pkg::ADDR_W-1 -: fbp_pkg::BLK_W] == ers_blk);
   endproperty
   a_erase_ones: assert property (p_erase_ones) else $error("erase not all ones"); // see RULE2

   property p_xo_deny;
      rd_req_in && prot_xo_in[rd_region] && (rd_src_in != fbp_pkg::SRC_FETCH)
         |=> rd_err_out && (rd_data_out == '0);
   endproperty
   a_xo_deny: assert property (p_xo_deny) else $error("xo read not denied"); // see RULE5

   property p_ro_pgm;
      pgm_req_in && idle && !ers_req_in && prot_ro_in[pgm_region] |-> !mem_we ##1 op_err_out;
   endproperty
   a_ro_pgm: assert property (p_ro_pgm) else $error("ro program not refused"); // see RULE4

   property p_xo_ers;
      ers_req_in && idle && prot_xo_in[ers_region] |=> !busy_out && op_err_out && !op_done_out;
   endproperty
   a_xo_ers: assert property (p_xo_ers) else $error("xo erase not refused"); // see RULE5

   property p_rd_one;
      rd_req_in && !rd_deny |=> rd_valid_out && !rd_err_out;
   endproperty
   a_rd_one: assert property (p_rd_one) else $error("read not single cycle"); // see RULE6

   property p_viol;
      op_err_out |-> violation_out;
   endproperty
   a_viol: assert property (p_viol) else $error("violation flag not set"); // see RULE7

   c_erase: cover property ($fell(busy_out));
   c_deny:  cover property (rd_err_out);
   c_clr:   cover property (viol_clr_in && next_err);
   c_pgm:   cover property (op_done_out && !$past(busy_out));
endmodule

// file: tb/fbp_req_model.sv
`timescale 1ns/100ps
module fbp_req_model (
   input  wire logic                  clk_in,
   output logic                       rd_req_out,
   output fbp_pkg::fbp_src_t          rd_src_out,
   output logic [fbp_pkg::ADDR_W-1:0] rd_addr_out,
   output logic                       pgm_req_out,
   output logic [fbp_pkg::ADDR_W-1:0] pgm_addr_out,
   output logic [fbp_pkg::DATA_W-1:0] pgm_wdata_out,
   output logic                       ers_req_out,
   output logic [fbp_pkg::BLK_W-1:0]  ers_blk_out
);
   initial begin
      rd_req_out = 1'b0;
      rd_src_out = fbp_pkg::SRC_FETCH;
      rd_addr_out = 13'h0000;
      pgm_req_out = 1'b0;
      pgm_addr_out = 13'h0000;
      pgm_wdata_out = 32'h00000000;
      ers_req_out = 1'b0;
      ers_blk_out = 5'h00;
   end

   // released addresses and data go to the inverse; rd_src_out keeps its last value
   task automatic rd(input fbp_pkg::fbp_src_t s, input logic [12:0] a, input bit hold);
      rd_req_out = 1'b1;
      rd_src_out = s;
      rd_addr_out = a;
      @(posedge clk_in);
      #1;
      // back to back: strobe and address stay for the next call to overwrite once
      if (!hold) begin
         rd_req_out = 1'b0;
         rd_addr_out = ~a;
      end
   endtask

   task automatic pgm(input logic [12:0] a, input logic [31:0] d);
      pgm_req_out = 1'b1;
      pgm_addr_out = a;
      pgm_wdata_out = d;
      @(posedge clk_in);
      #1;
      pgm_req_out = 1'b0;
      pgm_addr_out = ~a;
      pgm_wdata_out = ~d;
   endtask

   task automatic ers(input logic [4:0] b);
      ers_req_out = 1'b1;
      ers_blk_out = b;
      @(posedge clk_in);
      #1;
      ers_req_out = 1'b0;
      ers_blk_out = ~b;
   endtask
endmodule

// file: tb/fbp_top_tb_top.sv
`timescale 1ns/100ps
module fbp_top_tb_top;
   logic              clk_in = 1'b0;
   logic              rst_in = 1'b1;
   logic [15:0]       prot_ro = 16'h0000;
   logic [15:0]       prot_xo = 16'h0000;
   logic              viol_clr = 1'b0;
   logic              exp_viol = 1'b0;
   logic              last_rd = 1'b0;
   logic              rd_req, pgm_req, ers_req, rd_valid, rd_err, busy, op_done, op_err, viol;
   fbp_pkg::fbp_src_t rd_src;
   logic [12:0]       rd_addr, pgm_addr;
   logic [31:0]       pgm_wdata, rd_data;
   logic [4:0]        ers_blk;
   int                miscompares = 0;
   int                n_tests = 0;
   int                bcnt = 0;
   logic [32:0]       rq[$];
   logic [31:0]       oq[$];
   logic [31:0]       mem[int];
   logic [12:0]       al[$];

   always #5 clk_in = ~clk_in;

   fbp_req_model i_fbp_req_model (.clk_in(clk_in), .rd_req_out(rd_req), .rd_src_out(rd_src),
      .rd_addr_out(rd_addr), .pgm_req_out(pgm_req), .pgm_addr_out(pgm_addr),
      .pgm_wdata_out(pgm_wdata), .ers_req_out(ers_req), .ers_blk_out(ers_blk));

   fbp_top i_fbp_top (.clk_in(clk_in), .rst_in(rst_in), .prot_ro_in(prot_ro),
      .prot_xo_in(prot_xo), .rd_req_in(rd_req), .rd_src_in(rd_src), .rd_addr_in(rd_addr),
      .rd_valid_out(rd_valid), .rd_err_out(rd_err), .rd_data_out(rd_data),
      .pgm_req_in(pgm_req), .pgm_addr_in(pgm_addr), .pgm_wdata_in(pgm_wdata),
      .ers_req_in(ers_req), .ers_blk_in(ers_blk), .busy_out(busy), .op_done_out(op_done),
      .op_err_out(op_err), .viol_clr_in(viol_clr), .violation_out(viol));

   task automatic cmp_rd(input logic [32:0] e, input logic [32:0] a);
      n_tests++;
      if (a !== e) begin
         miscompares++;
         $display("[ERR] %0t exp %h got %h", $time, e, a);
      end
   endtask

   task automatic cmp_op(input logic [31:0] e, input logic [31:0] a);
      n_tests++;
      if (a !== e) begin
         miscompares++;
         $display("[ERR] %0t exp %h got %h", $time, e, a);
      end
   endtask

   task automatic report_and_stop;
      if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ****************************************
   // result watcher
   // ****************************************
   always @(posedge clk_in) last_rd <= rd_req & ~rst_in;

   always @(negedge clk_in) begin
      if (busy === 1'b1) bcnt++;
      if (last_rd === 1'b1) cmp_op(32'h1, 32'(rd_valid));
      if (rd_valid === 1'b1) begin
         cmp_rd(rq.size() ? rq.pop_front() : 33'hx, {rd_err, rd_data});
      end
      if (op_done === 1'b1 || op_err === 1'b1) begin
         cmp_op(oq.size() ? oq.pop_front() : 32'hx, 32'(op_err));
      end
   end

   // ****************************************
   // drivers that note expectations
   // ****************************************
   task automatic wait_idle;
      int k;
      for (k = 0; k < 400 && (rq.size() || oq.size()); k++) begin
         @(posedge clk_in);
         #1;
      end
      if (k == 400) begin
         cmp_op(32'h0, 32'(k));
         report_and_stop();
      end
      cmp_op(32'(exp_viol), 32'(viol));
   endtask

   task automatic rd(input fbp_pkg::fbp_src_t s, input logic [12:0] a, input bit hold);
      logic [32:0] e;
      e = (prot_xo[a[12:9]] && s != fbp_pkg::SRC_FETCH) ? {1'b1, 32'h0} : {1'b0, mem[a]};
      rq.push_back(e);
      i_fbp_req_model.rd(s, a, hold);
   endtask

   task automatic rd_all(input fbp_pkg::fbp_src_t s);
      // back to back, one request per cycle
      for (int i = 0; i < al.size(); i++) rd(s, al[i], i < al.size() - 1);
      wait_idle();
   endtask

   task automatic pgm(input logic [12:0] a, input logic [31:0] d);
      logic p;
      p = prot_ro[a[12:9]] | prot_xo[a[12:9]];
      oq.push_back(32'(p));
      exp_viol |= p;
      if (!p) mem[a] = d;
      i_fbp_req_model.pgm(a, d);
      wait_idle();
   endtask

   task automatic ers(input logic [4:0] b);
      logic p;
      int b0;
      p = prot_ro[b[4:1]] | prot_xo[b[4:1]];
      oq.push_back(32'(p));
      exp_viol |= p;
      b0 = bcnt;
      if (!p) for (int i = 0; i < 256; i++) mem[{b, 8'(i)}] = 32'hffffffff;
      i_fbp_req_model.ers(b);
      wait_idle();
      cmp_op(p ? 32'h0 : 32'h100, 32'(bcnt - b0));
   endtask

   initial begin
      void'($urandom(32'hd551f47a));
      repeat (12) @(posedge clk_in);
      #1;
      rst_in = 1'b0;
      ers(5'h02);
      ers(5'h03);
      for (int i = 0; i < 8; i++) al.push_back({4'h1, 9'($urandom)});
      foreach (al[i]) pgm(al[i], $urandom);
      al.push_back(13'h0200);
      al.push_back(13'h03ff);
      rd_all(fbp_pkg::SRC_DATA);
      // block 3 alone back to all ones, block 2 kept
      ers(5'h03);
      rd_all(fbp_pkg::SRC_DEBUG);
      for (int m = 0; m < 2; m++) begin
         prot_ro = (m == 0) ? 16'h0002 : 16'h0000;
         prot_xo = (m == 0) ? 16'h0000 : 16'h0002;
         pgm(al[0], $urandom);
         ers(5'h02);
         ers(5'h03);
         for (int s = 0; s < 3; s++) rd_all(fbp_pkg::fbp_src_t'(s));
         // neighbour region stays open
         ers(5'h04);
         viol_clr = 1'b1;
         exp_viol = 1'b0;
         @(posedge clk_in);
         #1;
         viol_clr = 1'b0;
         wait_idle();
      end
      report_and_stop();
   end
endmodule
